// ===== hw/mcg_pkg.sv
// package of constants and types for the module clock gating block
package mcg_pkg;
   localparam int unsigned SLOT_COUNT = 40;
   localparam int unsigned SLOT_CPU = 39;
   localparam int unsigned SLOT_DDR = 13;
   localparam int unsigned SLOT_EMAC_MEM = 6;
   localparam int unsigned SLOT_EMAC = 8;
   // set bits mark slots that have a module behind them
   localparam logic [39:0] SLOT_PRESENT = 40'h80_1FDF_FBFF;
   localparam int unsigned IO_GROUPS = 8;
   localparam int unsigned DAC_COUNT = 4;
   localparam int unsigned PLL_MULT_W = 5;
   localparam logic [4:0] PLL_MULT_RESET = 5'h00;
   localparam logic [39:0] GATE_RESET = 40'h00_0000_0000;
   localparam logic [7:0] IO_PWDN_RESET = 8'h00;
   localparam logic [3:0] DAC_RESET = 4'h0;
   localparam logic OSC_EN_RESET = 1'b1;
   localparam logic PLL_EN_RESET = 1'b0;
   localparam logic HAS_DSP_POWER_BIT = 1'b0;
   // global_power_controller slot state
   typedef enum logic [1:0] {
      MCG_OFF = 2'b00,
      MCG_ENABLING = 2'b01,
      MCG_ON = 2'b10,
      MCG_DISABLING = 2'b11
   } mcg_slot_t;
endpackage : mcg_pkg

// ===== hw/mcg_power_sleep_controller.sv
// power_sleep_controller: per-slot clock gates, io power-down, pll and dac enables
// Function
// - each module clock switched on/off independently
// - global part: control logic and per-slot machine
// - forty slots, some reserved and unconnected
// - slot 39 gates the DSP core clock
// - slot 13 gates the DDR2 controller clock
// - slot 6 gates EMAC memory controller separately
// - io_buffer_powerdown_register bits gate only buffers
// - no dsp_power_on_bit on single-DSP variant
// - pll_control_register enables oscillator and PLL
// - video_mode/dac_test registers enable video DACs
// - clocks valid while reset asserted
// - oscillator enabled during reset by default
// - reset clock mode fixed at x1
// - multiplier changeable by software after reset
`timescale 1ns/1ps
module mcg_power_sleep_controller (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic [mcg_pkg::SLOT_COUNT-1:0] i_gate_wr,
   input wire logic [mcg_pkg::SLOT_COUNT-1:0] i_gate_val,
   input wire logic i_io_pwdn_wr,
   input wire logic [mcg_pkg::IO_GROUPS-1:0] i_io_pwdn_val,
   input wire logic i_pll_wr,
   input wire logic i_osc_en_val,
   input wire logic i_pll_en_val,
   input wire logic [mcg_pkg::PLL_MULT_W-1:0] i_pll_mult_val,
   input wire logic i_dac_wr,
   input wire logic [mcg_pkg::DAC_COUNT-1:0] i_dac_en_val,
   output logic [mcg_pkg::SLOT_COUNT-1:0] o_gate_en,
   output logic [mcg_pkg::SLOT_COUNT-1:0] o_gate_status,
   output logic o_transition_done,
   output logic [mcg_pkg::IO_GROUPS-1:0] o_io_pwdn,
   output logic o_osc_en,
   output logic o_pll_en,
   output logic [mcg_pkg::PLL_MULT_W-1:0] o_pll_mult,
   output logic [mcg_pkg::DAC_COUNT-1:0] o_dac_en,
   output logic o_dsp_core_clk_en,
   output logic o_ddr_clk_en,
   output logic o_emac_mem_clk_en
);
   import mcg_pkg::*;

   typedef struct packed {
      mcg_slot_t [SLOT_COUNT-1:0] slot;
      logic [SLOT_COUNT-1:0] gate;
      logic done;
      logic [IO_GROUPS-1:0] io_pwdn;
      logic osc_en;
      logic pll_en;
      logic [PLL_MULT_W-1:0] mult;
      logic [DAC_COUNT-1:0] dac;
      logic cpu;
      logic ddr;
      logic emac_mem;
   } mcg_state_t;

   mcg_state_t state_q;
   mcg_state_t state_d;

   function automatic mcg_slot_t slot_next(input mcg_slot_t cur, input logic wr,
                                           input logic val);
      mcg_slot_t nxt;
      nxt = cur;
      unique case (cur)
         MCG_OFF: begin
            if (wr && val) nxt = MCG_ENABLING;
         end
         MCG_ENABLING: nxt = MCG_ON;
         MCG_ON: begin
            if (wr && !val) nxt = MCG_DISABLING;
         end
         MCG_DISABLING: nxt = MCG_OFF;
      endcase
      return nxt;
   endfunction : slot_next

   always_comb begin
      logic [SLOT_COUNT-1:0] fin;
      fin = '0;
      state_d = state_q;
      for (int i = 0; i < SLOT_COUNT; i++) begin
         if (SLOT_PRESENT[i]) begin
            state_d.slot[i] = slot_next(state_q.slot[i], i_gate_wr[i], i_gate_val[i]);
         end else begin
            state_d.slot[i] = MCG_OFF;
         end
         fin[i] = (state_q.slot[i] == MCG_ENABLING) || (state_q.slot[i] == MCG_DISABLING);
         state_d.gate[i] = (state_d.slot[i] == MCG_ON) || (state_d.slot[i] == MCG_DISABLING);
      end
      state_d.done = |fin;
      state_d.cpu = state_d.gate[SLOT_CPU];
      state_d.ddr = state_d.gate[SLOT_DDR];
      state_d.emac_mem = state_d.gate[SLOT_EMAC_MEM];
      if (i_io_pwdn_wr) state_d.io_pwdn = i_io_pwdn_val;
      if (i_pll_wr) begin
         state_d.osc_en = i_osc_en_val;
         state_d.pll_en = i_pll_en_val;
         state_d.mult = i_pll_mult_val;
      end
      if (i_dac_wr) state_d.dac = i_dac_en_val;
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < SLOT_COUNT; i++) begin
            state_q.slot[i] <= MCG_OFF;
         end
         state_q.gate <= GATE_RESET;
         state_q.done <= 1'b0;
         state_q.io_pwdn <= IO_PWDN_RESET;
         state_q.osc_en <= OSC_EN_RESET;
         state_q.pll_en <= PLL_EN_RESET;
         state_q.mult <= PLL_MULT_RESET;
         state_q.dac <= DAC_RESET;
         state_q.cpu <= 1'b0;
         state_q.ddr <= 1'b0;
         state_q.emac_mem <= 1'b0;
      end else if (i_clk_en) begin
         state_q <= state_d;
      end
   end

   // the dsp_power_on_bit does not exist on this variant
   assign o_gate_en = state_q.gate;
   assign o_gate_status = state_q.gate;
   assign o_transition_done = state_q.done;
   assign o_io_pwdn = state_q.io_pwdn;
   assign o_osc_en = state_q.osc_en;
   assign o_pll_en = state_q.pll_en;
   assign o_pll_mult = state_q.mult;
   assign o_dac_en = state_q.dac;
   assign o_dsp_core_clk_en = state_q.cpu;
   assign o_ddr_clk_en = state_q.ddr;
   assign o_emac_mem_clk_en = state_q.emac_mem;

   property p_reserved_off;
      @(posedge i_clock) disable iff (!i_rst_n)
      1'b1 |-> ((o_gate_en & ~SLOT_PRESENT) == '0);
   endproperty
   a_reserved_off: assert property (p_reserved_off) else $error("reserved slot gated on");

   property p_enable_two;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && i_gate_wr[SLOT_DDR] && i_gate_val[SLOT_DDR] && !o_ddr_clk_en
       && state_q.slot[SLOT_DDR] == MCG_OFF) ##1 i_clk_en |=> o_ddr_clk_en;
   endproperty
   a_enable_two: assert property (p_enable_two) else $error("ddr gate slow to enable");

   property p_cpu_tracks;
      @(posedge i_clock) disable iff (!i_rst_n)
      o_dsp_core_clk_en == o_gate_en[SLOT_CPU] && o_emac_mem_clk_en == o_gate_en[SLOT_EMAC_MEM];
   endproperty
   a_cpu_tracks: assert property (p_cpu_tracks) else $error("named gate mismatch");

   property p_io_indep;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && i_io_pwdn_wr && !(|i_gate_wr)) |=> $stable(o_gate_en) || o_transition_done;
   endproperty
   a_io_indep: assert property (p_io_indep) else $error("io write touched gates");

   property p_pll_write;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && i_pll_wr) |=> (o_pll_mult == $past(i_pll_mult_val)
                                  && o_osc_en == $past(i_osc_en_val));
   endproperty
   a_pll_write: assert property (p_pll_write) else $error("pll write lost");

   property p_dac_write;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && i_dac_wr) |=> o_dac_en == $past(i_dac_en_val);
   endproperty
   a_dac_write: assert property (p_dac_write) else $error("dac write lost");

   property p_hold;
      @(posedge i_clock) disable iff (!i_rst_n)
      !i_clk_en |=> $stable(o_gate_en) && $stable(o_pll_mult);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved while frozen");

   property p_reset_mode;
      @(posedge i_clock) $rose(i_rst_n) |-> o_osc_en && o_pll_mult == PLL_MULT_RESET;
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("bad reset clock mode");

   property p_disable_two;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && i_gate_wr[SLOT_DDR] && !i_gate_val[SLOT_DDR]
       && state_q.slot[SLOT_DDR] == MCG_ON) ##1 i_clk_en
      |-> o_ddr_clk_en ##1 (!o_ddr_clk_en && o_transition_done);
   endproperty
   a_disable_two: assert property (p_disable_two) else $error("ddr slow to stop");

   property p_cpu_done;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && state_q.slot[SLOT_CPU] == MCG_ENABLING) |=> o_transition_done && o_dsp_core_clk_en;
   endproperty
   a_cpu_done: assert property (p_cpu_done) else $error("cpu step unseen");

   property p_emac_apart;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && state_q.slot[SLOT_EMAC_MEM] == MCG_ENABLING && !i_gate_wr[SLOT_EMAC]
       && state_q.slot[SLOT_EMAC] == MCG_OFF) |=> o_emac_mem_clk_en && !o_gate_en[SLOT_EMAC];
   endproperty
   a_emac_apart: assert property (p_emac_apart) else $error("emac gates merged");

   property p_rsv_write;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && (i_gate_wr & ~SLOT_PRESENT) != '0) |=> ((o_gate_status & ~SLOT_PRESENT) == '0);
   endproperty
   a_rsv_write: assert property (p_rsv_write) else $error("reserved slot on");

   property p_io_write;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && i_io_pwdn_wr) |=> o_io_pwdn == $past(i_io_pwdn_val);
   endproperty
   a_io_write: assert property (p_io_write) else $error("io write lost");

   property p_pll_enable;
      @(posedge i_clock) disable iff (!i_rst_n)
      (i_clk_en && i_pll_wr) |=> o_pll_en == $past(i_pll_en_val);
   endproperty
   a_pll_enable: assert property (p_pll_enable) else $error("pll enable lost");

   // while reset is held the clock outputs already carry their start-up values
   property p_reset_hold;
      @(posedge i_clock) !i_rst_n ##1 !i_rst_n |-> o_osc_en == OSC_EN_RESET
         && o_pll_en == PLL_EN_RESET && o_pll_mult == PLL_MULT_RESET && o_gate_en == GATE_RESET;
   endproperty
   a_reset_hold: assert property (p_reset_hold) else $error("bad reset state");
endmodule : mcg_power_sleep_controller

// ===== verification/mcg_clock_sink_model.sv
// model of a peripheral that runs only while its gated clock is on
`timescale 1ns/1ps
module mcg_clock_sink_model (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_gate,
   output logic [15:0] o_ticks
);
   // counts the clock edges the module really received
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) o_ticks <= 16'h0000;
      else if (i_gate) o_ticks <= o_ticks + 16'h0001;
   end
endmodule : mcg_clock_sink_model

// ===== verification/module_clock_gating_and_reset_clocking_tb.sv
// testbench for the power sleep controller
`timescale 1ns/1ps
module module_clock_gating_and_reset_clocking_tb;
   import mcg_pkg::*;
   logic i_clock = 0, i_rst_n = 0, en = 1, iow = 0, pw = 0, osc = 0, pen = 0, dw = 0;
   logic [39:0] gw = '0, gv = '0, ge, gs;
   logic [7:0] iov = '0, io;
   logic [4:0] mv = '0, m;
   logic [3:0] dv = '0, da;
   logic done, oo, po, cpu, ddr, emm;
   logic [15:0] ticks;
   int error_cnt = 0, samples_checked = 0;
   mcg_power_sleep_controller mcg_power_sleep_controller_inst (.i_clock(i_clock),
      .i_rst_n(i_rst_n), .i_clk_en(en), .i_gate_wr(gw), .i_gate_val(gv),
      .i_io_pwdn_wr(iow), .i_io_pwdn_val(iov), .i_pll_wr(pw), .i_osc_en_val(osc),
      .i_pll_en_val(pen), .i_pll_mult_val(mv), .i_dac_wr(dw), .i_dac_en_val(dv),
      .o_gate_en(ge), .o_gate_status(gs), .o_transition_done(done), .o_io_pwdn(io),
      .o_osc_en(oo), .o_pll_en(po), .o_pll_mult(m), .o_dac_en(da),
      .o_dsp_core_clk_en(cpu), .o_ddr_clk_en(ddr), .o_emac_mem_clk_en(emm));
   mcg_clock_sink_model mcg_clock_sink_model_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_gate(ddr), .o_ticks(ticks));
   initial begin
      forever #2 i_clock = ~i_clock;
   end
   task automatic results;
      if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : tick
   // strobe one slot; returns just after the edge that takes it
   task automatic gate(input int s, input logic v);
      @(posedge i_clock);
      gw[s] <= 1'b1;
      gv[s] <= v;
      @(posedge i_clock);
      gw[s] <= 1'b0;
      #1;
   endtask : gate
   // v packs io bits, osc, pll, multiplier and dac bits
   task automatic load(input logic [2:0] s, input logic [18:0] v);
      @(posedge i_clock);
      {iow, pw, dw} <= s;
      {iov, osc, pen, mv, dv} <= v;
      @(posedge i_clock);
      {iow, pw, dw} <= 3'b000;
      tick(1);
   endtask : load
   initial begin
      tick(2);
      cmp({oo, po, m, ge}, {2'b10, PLL_MULT_RESET, GATE_RESET});
      @(posedge i_clock);
      i_rst_n <= 1'b1;
      tick(1);
      cmp({oo, m, io, da}, {1'b1, PLL_MULT_RESET, IO_PWDN_RESET, DAC_RESET});
      gate(SLOT_DDR, 1'b1);
      cmp({ge[SLOT_DDR], done}, 2'b00);
      tick(1);
      cmp({ge[SLOT_DDR], ddr, done, gs[SLOT_DDR], ticks}, {4'hF, 16'h0000});
      tick(1);
      cmp({done, ticks}, {1'b0, 16'h0001});
      gate(SLOT_EMAC_MEM, 1'b1);
      tick(1);
      cmp({emm, ge[SLOT_EMAC]}, 2'b10);
      gate(SLOT_CPU, 1'b1);
      tick(1);
      cmp(cpu, 1'b1);
      gate(10, 1'b1);
      tick(2);
      cmp({ge[10], gs[10], done}, 3'b000);
      gate(21, 1'b1);
      gate(22, 1'b1);
      tick(1);
      cmp({ge[21], gs[21], ge[22], gs[22]}, 4'h3);
      load(3'b010, {8'hA5, 1'b0, 1'b1, 5'h03, 4'h0});
      cmp({oo, po, m, io}, {2'b01, 5'h03, 8'h00});
      load(3'b100, {8'hA5, 1'b1, 1'b0, 5'h00, 4'h0});
      cmp({io, oo, ge}, {8'hA5, 1'b0, 40'h80_0040_2040});
      load(3'b001, {8'h00, 1'b1, 1'b0, 5'h00, 4'hA});
      cmp({da, io}, {4'hA, 8'hA5});
      @(posedge i_clock);
      en <= 1'b0;
      gate(SLOT_DDR, 1'b0);
      tick(3);
      cmp(ge, 40'h80_0040_2040);
      @(posedge i_clock);
      en <= 1'b1;
      gate(SLOT_DDR, 1'b0);
      cmp(ge[SLOT_DDR], 1'b1);
      tick(1);
      cmp({ge, ddr, done}, {40'h80_0040_0040, 2'b01});
      repeat (2) @(posedge i_clock);
      i_rst_n <= 1'b0;
      tick(1);
      cmp({oo, po, m, ge}, {2'b10, PLL_MULT_RESET, GATE_RESET});
      @(posedge i_clock);
      i_rst_n <= 1'b1;
      tick(1);
      cmp({oo, m, io, da}, {1'b1, PLL_MULT_RESET, IO_PWDN_RESET, DAC_RESET});
      results();
   end
   initial begin
      #20000;
      error_cnt++;
      results();
   end
endmodule : module_clock_gating_and_reset_clocking_tb
